// *** hdl/lnc_pkg.sv ***
// Package for the level detector and carrier NCO control words.
// Assumes one clock (the input sample clock) and a control word write port on that clock.
package lnc_pkg;

    // Control word numbers seen on the write port address
    localparam logic [7:0] LNC_CW_LEVEL_CONFIG    = 8'h01;
    localparam logic [7:0] LNC_CW_LEVEL_START     = 8'h02;
    localparam logic [7:0] LNC_CW_CENTER_FREQ     = 8'h03;
    localparam logic [7:0] LNC_CW_PHASE_OFFSET    = 8'h04;
    localparam logic [7:0] LNC_CW_FREQ_STROBE     = 8'h05;
    localparam logic [7:0] LNC_CW_PHASE_STROBE    = 8'h06;

    // Level detector configuration word layout
    localparam int LNC_INTEG_MODE_BIT    = 30;
    localparam int LNC_INTERVAL_MSB      = 29;
    localparam int LNC_INTERVAL_LSB      = 14;
    localparam int LNC_THRESHOLD_MSB     = 13;
    localparam int LNC_THRESHOLD_LSB     = 0;
    localparam int LNC_INTERVAL_W        = 16;
    localparam int LNC_COUNTER_W         = 18;
    localparam int LNC_THRESHOLD_W       = 14;

    // Carrier words
    localparam int LNC_FREQ_W            = 32;
    localparam int LNC_PHASE_W           = 10;
    localparam int LNC_PHASE_MSB         = 9;

    // Input samples and integrator
    localparam int LNC_SAMPLE_W          = 14;
    localparam int LNC_ACC_W             = 34;

    // Values after reset
    localparam logic [30:0] LNC_LEVEL_CONFIG_RESET = 31'h0;
    localparam logic [31:0] LNC_FREQ_RESET         = 32'h0;
    localparam logic [9:0]  LNC_PHASE_RESET        = 10'h0;
    localparam logic [31:0] LNC_ACCUM_RESET        = 32'h0;

    // Interval counter holds (preload - 1) times four, one count per input clock
    localparam logic [17:0] LNC_SAMPLES_PER_COUNT  = 18'h4;

    typedef enum logic [1:0] {
        LNC_LD_IDLE,
        LNC_LD_RUN,
        LNC_LD_DONE
    } lnc_ld_state_t;

endpackage

// *** hdl/lnc_level_detector.sv ***
// Input level detector: integrates sample magnitude plus a signed threshold over an interval.
// Assumes samples and enables already synchronised to the input sample clock.
`timescale 1ns/1ps
module lnc_level_detector #(
    parameter int ACC_W = lnc_pkg::LNC_ACC_W
) (
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_n_in,
    input  wire logic                                   start_in,
    input  wire logic                                   continuous_in,
    input  wire logic [lnc_pkg::LNC_INTERVAL_W-1:0]     interval_in,
    input  wire logic [lnc_pkg::LNC_THRESHOLD_W-1:0]    threshold_in,
    input  wire logic [lnc_pkg::LNC_SAMPLE_W-1:0]       sample_in,
    output logic [ACC_W-1:0]                            result_out,
    output logic                                        result_valid_out,
    output logic                                        busy_out
);
    import lnc_pkg::*;

    lnc_ld_state_t              state;
    logic [LNC_COUNTER_W-1:0]   remaining;
    logic [ACC_W-1:0]           acc;
    logic [LNC_COUNTER_W-1:0]   period;
    logic [LNC_SAMPLE_W-1:0]    magnitude;
    logic [ACC_W-1:0]           term;

    ////////////////////////////////////////////////////////////////////////////
    // Period in cycles is four times (preload - 1); preload zero treated as one
    always_comb begin
        if (interval_in == '0) begin
            period = '0;
        end else begin
            period = {interval_in, 2'b00} - LNC_SAMPLES_PER_COUNT;
        end
    end

    // Magnitude of a two's complement sample; most negative saturates
    always_comb begin
        if (sample_in[LNC_SAMPLE_W-1]) begin
            magnitude = (sample_in == {1'b1, {(LNC_SAMPLE_W-1){1'b0}}}) ? {1'b0, {(LNC_SAMPLE_W-1){1'b1}}}
                                                                         : (~sample_in) + 14'h1;
        end else begin
            magnitude = sample_in;
        end
        term = ACC_W'($signed(threshold_in)) + ACC_W'(magnitude);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state            <= LNC_LD_IDLE;
            remaining        <= '0;
            acc              <= '0;
            result_out       <= '0;
            result_valid_out <= 1'b0;
            busy_out         <= 1'b0;
        end else begin
            result_valid_out <= 1'b0;
            if (start_in) begin
                // Start or restart always clears the running sum
                state     <= LNC_LD_RUN;
                remaining <= period;
                acc       <= '0;
                busy_out  <= 1'b1;
            end else begin
                case (state)
                    LNC_LD_RUN: begin
                        if (remaining != '0) begin
                            // Every clock counts, zero stuffed or repeated samples included
                            acc       <= acc + term;
                            remaining <= remaining - 18'h1;
                        end else if (continuous_in) begin
                            result_out       <= acc;
                            result_valid_out <= 1'b1;
                            acc              <= (period == '0) ? '0 : term;
                            remaining        <= (period == '0) ? '0 : period - 18'h1;
                        end else begin
                            result_out       <= acc;
                            result_valid_out <= 1'b1;
                            state            <= LNC_LD_DONE;
                            busy_out         <= 1'b0;
                        end
                    end
                    LNC_LD_DONE: begin
                        state <= LNC_LD_DONE;
                    end
                    default: begin
                        state <= LNC_LD_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // lnc_level_detector

// *** hdl/lnc_control_words.sv ***
// Level detector and carrier NCO control words with holding and active registers.
// Assumes the control word write port runs on CLK_IN; sync and enable arrive from pins.
`timescale 1ns/1ps
module lnc_control_words #(
    parameter int ACC_W = lnc_pkg::LNC_ACC_W
) (
    input  wire logic                                CLK_IN,
    input  wire logic                                RST_N_IN,
    input  wire logic                                WR_STROBE_IN,
    input  wire logic [7:0]                          WR_ADDR_IN,
    input  wire logic [31:0]                         WR_DATA_IN,
    input  wire logic                                NCO_SYNC_ENABLE_IN,
    input  wire logic                                FRONT_SYNC_PULSE_IN,
    input  wire logic                                SAMPLE_ENABLE_LOW_IN,
    input  wire logic [lnc_pkg::LNC_SAMPLE_W-1:0]    SAMPLE_IN,
    output logic [lnc_pkg::LNC_FREQ_W-1:0]           ACTIVE_FREQUENCY_OUT,
    output logic [lnc_pkg::LNC_PHASE_W-1:0]          ACTIVE_PHASE_OFFSET_OUT,
    output logic [lnc_pkg::LNC_FREQ_W-1:0]           NCO_ACCUM_OUT,
    output logic [lnc_pkg::LNC_PHASE_W-1:0]          CARRIER_PHASE_OUT,
    output logic                                     SYNC_LOAD_PENDING_OUT,
    output logic                                     FREQ_LOAD_PENDING_OUT,
    output logic                                     PHASE_LOAD_PENDING_OUT,
    output logic [ACC_W-1:0]                         LEVEL_RESULT_OUT,
    output logic                                     LEVEL_RESULT_VALID_OUT,
    output logic                                     LEVEL_BUSY_OUT
);
    import lnc_pkg::*;

    // Write decode shared by every control word
    function automatic logic word_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] word);
        word_hit = strobe && (addr == word);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic                        sync_meta;
    logic                        sync_stable;
    logic                        sync_prev;
    logic                        enable_low_meta;
    logic                        enable_low_stable;
    logic [LNC_SAMPLE_W-1:0]     sample_meta;
    logic [LNC_SAMPLE_W-1:0]     sample_stable;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sync_meta   <= 1'b0;
            sync_stable <= 1'b0;
            sync_prev   <= 1'b0;
        end else begin
            sync_meta   <= FRONT_SYNC_PULSE_IN;
            sync_stable <= sync_meta;
            sync_prev   <= sync_stable;
        end
    end

    // Enable idles inactive (high) so the NCO does not advance before the pin is seen
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            enable_low_meta   <= 1'b1;
            enable_low_stable <= 1'b1;
        end else begin
            enable_low_meta   <= SAMPLE_ENABLE_LOW_IN;
            enable_low_stable <= enable_low_meta;
        end
    end

    // Samples take the same two stages so they stay aligned with the enable
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sample_meta   <= '0;
            sample_stable <= '0;
        end else begin
            sample_meta   <= SAMPLE_IN;
            sample_stable <= sample_meta;
        end
    end

    logic nco_update;
    logic sync_rise;

    assign nco_update = !enable_low_stable;
    assign sync_rise  = sync_stable && !sync_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    logic wr_level_config;
    logic wr_level_start;
    logic wr_center_freq;
    logic wr_phase_offset;
    logic wr_freq_strobe;
    logic wr_phase_strobe;

    always_comb begin
        wr_level_config = 1'b0;
        wr_level_start  = 1'b0;
        wr_center_freq  = 1'b0;
        wr_phase_offset = 1'b0;
        wr_freq_strobe  = 1'b0;
        wr_phase_strobe = 1'b0;
        if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_LEVEL_CONFIG)) begin
            wr_level_config = 1'b1;
        end else if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_LEVEL_START)) begin
            wr_level_start = 1'b1;
        end else if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_CENTER_FREQ)) begin
            wr_center_freq = 1'b1;
        end else if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_PHASE_OFFSET)) begin
            wr_phase_offset = 1'b1;
        end else if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_FREQ_STROBE)) begin
            wr_freq_strobe = 1'b1;
        end else if (word_hit(WR_STROBE_IN, WR_ADDR_IN, LNC_CW_PHASE_STROBE)) begin
            wr_phase_strobe = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level detector configuration word; bit 31 is not stored
    logic [30:0]                 level_config;
    logic                        level_start;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            level_config <= LNC_LEVEL_CONFIG_RESET;
        end else if (wr_level_config) begin
            level_config <= WR_DATA_IN[30:0];
        end
    end

    // Start strobe carries no data; registered so the config write path settles first
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            level_start <= 1'b0;
        end else begin
            level_start <= wr_level_start;
        end
    end

    lnc_level_detector #(
        .ACC_W (ACC_W)
    ) u_level_detector (
        .clk_in           (CLK_IN),
        .rst_n_in         (RST_N_IN),
        .start_in         (level_start),
        .continuous_in    (level_config[LNC_INTEG_MODE_BIT]),
        .interval_in      (level_config[LNC_INTERVAL_MSB:LNC_INTERVAL_LSB]),
        .threshold_in     (level_config[LNC_THRESHOLD_MSB:LNC_THRESHOLD_LSB]),
        .sample_in        (sample_stable),
        .result_out       (LEVEL_RESULT_OUT),
        .result_valid_out (LEVEL_RESULT_VALID_OUT),
        .busy_out         (LEVEL_BUSY_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Holding registers
    logic [LNC_FREQ_W-1:0]       freq_holding;
    logic [LNC_PHASE_W-1:0]      phase_holding;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            freq_holding <= LNC_FREQ_RESET;
        end else if (wr_center_freq) begin
            freq_holding <= WR_DATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            phase_holding <= LNC_PHASE_RESET;
        end else if (wr_phase_offset) begin
            phase_holding <= WR_DATA_IN[LNC_PHASE_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending transfers; a new request in the cycle that consumes an old one survives
    logic next_sync_pending;
    logic next_freq_pending;
    logic next_phase_pending;
    logic sync_request;

    assign sync_request = sync_rise && NCO_SYNC_ENABLE_IN;

    always_comb begin
        next_sync_pending  = (SYNC_LOAD_PENDING_OUT && !nco_update) || sync_request;
        next_freq_pending  = (FREQ_LOAD_PENDING_OUT && !nco_update) || wr_freq_strobe;
        next_phase_pending = (PHASE_LOAD_PENDING_OUT && !nco_update) || wr_phase_strobe;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            SYNC_LOAD_PENDING_OUT  <= 1'b0;
            FREQ_LOAD_PENDING_OUT  <= 1'b0;
            PHASE_LOAD_PENDING_OUT <= 1'b0;
        end else begin
            SYNC_LOAD_PENDING_OUT  <= next_sync_pending;
            FREQ_LOAD_PENDING_OUT  <= next_freq_pending;
            PHASE_LOAD_PENDING_OUT <= next_phase_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active registers move only on NCO update cycles
    logic load_freq;
    logic load_phase;

    assign load_freq  = nco_update && (FREQ_LOAD_PENDING_OUT || SYNC_LOAD_PENDING_OUT);
    assign load_phase = nco_update && (PHASE_LOAD_PENDING_OUT || SYNC_LOAD_PENDING_OUT);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ACTIVE_FREQUENCY_OUT <= LNC_FREQ_RESET;
        end else if (load_freq) begin
            ACTIVE_FREQUENCY_OUT <= freq_holding;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ACTIVE_PHASE_OFFSET_OUT <= LNC_PHASE_RESET;
        end else if (load_phase) begin
            ACTIVE_PHASE_OFFSET_OUT <= phase_holding;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier phase accumulator; increment is the frequency ratio times 2^32
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            NCO_ACCUM_OUT <= LNC_ACCUM_RESET;
        end else if (nco_update) begin
            NCO_ACCUM_OUT <= NCO_ACCUM_OUT + ACTIVE_FREQUENCY_OUT;
        end
    end

    // Modulo add means signed and offset binary offsets need no separate path
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            CARRIER_PHASE_OUT <= LNC_PHASE_RESET;
        end else if (nco_update) begin
            CARRIER_PHASE_OUT <= NCO_ACCUM_OUT[LNC_FREQ_W-1 -: LNC_PHASE_W] + ACTIVE_PHASE_OFFSET_OUT;
        end
    end

endmodule // lnc_control_words

// *** verif/lnc_control_words_props.sv ***
// Port-level checker for the level detector and carrier NCO control words.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lnc_control_words_props
    import lnc_pkg::*;
#(
    parameter int ACC_W = LNC_ACC_W
) (
    input wire logic             CLK_IN,
    input wire logic             RST_N_IN,
    input wire logic             WR_STROBE_IN,
    input wire logic [7:0]       WR_ADDR_IN,
    input wire logic             NCO_SYNC_ENABLE_IN,
    input wire logic             FRONT_SYNC_PULSE_IN,
    input wire logic             SAMPLE_ENABLE_LOW_IN,
    input wire logic [31:0]      ACTIVE_FREQUENCY_OUT,
    input wire logic [9:0]       ACTIVE_PHASE_OFFSET_OUT,
    input wire logic [31:0]      NCO_ACCUM_OUT,
    input wire logic             SYNC_LOAD_PENDING_OUT,
    input wire logic             FREQ_LOAD_PENDING_OUT,
    input wire logic             PHASE_LOAD_PENDING_OUT,
    input wire logic [ACC_W-1:0] LEVEL_RESULT_OUT,
    input wire logic             LEVEL_RESULT_VALID_OUT,
    input wire logic             LEVEL_BUSY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////////////////////////////////////////////
    freq_hold_a: assert property (!$stable(ACTIVE_FREQUENCY_OUT) |->
        $past(FREQ_LOAD_PENDING_OUT) || $past(SYNC_LOAD_PENDING_OUT)) else $error("frequency moved unasked");
    phase_hold_a: assert property (!$stable(ACTIVE_PHASE_OFFSET_OUT) |->
        $past(PHASE_LOAD_PENDING_OUT) || $past(SYNC_LOAD_PENDING_OUT)) else $error("phase moved unasked");
    freq_strobe_a: assert property (WR_STROBE_IN && WR_ADDR_IN == LNC_CW_FREQ_STROBE |=>
        FREQ_LOAD_PENDING_OUT) else $error("frequency strobe lost");
    phase_strobe_a: assert property (WR_STROBE_IN && WR_ADDR_IN == LNC_CW_PHASE_STROBE |=>
        PHASE_LOAD_PENDING_OUT) else $error("phase strobe lost");
    // Three idle samples tolerate one cycle of doubt in the pin pipeline depth
    nco_still_a: assert property ($past(SAMPLE_ENABLE_LOW_IN, 2) && $past(SAMPLE_ENABLE_LOW_IN, 3) &&
        $past(SAMPLE_ENABLE_LOW_IN, 4) |-> $stable(NCO_ACCUM_OUT)) else $error("NCO moved while idle");
    sync_seen_a: assert property ($rose(FRONT_SYNC_PULSE_IN) && NCO_SYNC_ENABLE_IN |->
        ##[1:5] SYNC_LOAD_PENDING_OUT) else $error("sync load not remembered");
    start_busy_a: assert property (WR_STROBE_IN && WR_ADDR_IN == LNC_CW_LEVEL_START |->
        ##[1:3] LEVEL_BUSY_OUT) else $error("start did not run integrator");
    valid_pulse_a: assert property (LEVEL_RESULT_VALID_OUT |=> !LEVEL_RESULT_VALID_OUT)
        else $error("valid longer than one cycle");
    result_hold_a: assert property (!$stable(LEVEL_RESULT_OUT) |->
        LEVEL_RESULT_VALID_OUT || $past(LEVEL_RESULT_VALID_OUT)) else $error("result moved without latch");
    busy_end_a: assert property ($fell(LEVEL_BUSY_OUT) && !$past(WR_STROBE_IN) && !$past(WR_STROBE_IN, 2) |->
        (LEVEL_RESULT_VALID_OUT || $past(LEVEL_RESULT_VALID_OUT)) or (##1 LEVEL_RESULT_VALID_OUT))
        else $error("integrator stopped without result");
endmodule // lnc_control_words_props

bind lnc_control_words lnc_control_words_props #(.ACC_W(ACC_W)) u_props (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .WR_STROBE_IN(WR_STROBE_IN), .WR_ADDR_IN(WR_ADDR_IN),
    .NCO_SYNC_ENABLE_IN(NCO_SYNC_ENABLE_IN), .FRONT_SYNC_PULSE_IN(FRONT_SYNC_PULSE_IN),
    .SAMPLE_ENABLE_LOW_IN(SAMPLE_ENABLE_LOW_IN), .ACTIVE_FREQUENCY_OUT(ACTIVE_FREQUENCY_OUT),
    .ACTIVE_PHASE_OFFSET_OUT(ACTIVE_PHASE_OFFSET_OUT), .NCO_ACCUM_OUT(NCO_ACCUM_OUT),
    .SYNC_LOAD_PENDING_OUT(SYNC_LOAD_PENDING_OUT), .FREQ_LOAD_PENDING_OUT(FREQ_LOAD_PENDING_OUT),
    .PHASE_LOAD_PENDING_OUT(PHASE_LOAD_PENDING_OUT), .LEVEL_RESULT_OUT(LEVEL_RESULT_OUT),
    .LEVEL_RESULT_VALID_OUT(LEVEL_RESULT_VALID_OUT), .LEVEL_BUSY_OUT(LEVEL_BUSY_OUT));

// *** verif/lnc_host_model.sv ***
// Model of the processor write port and the external sync source.
// Assumes its caller waits off the clock edge between calls.
`timescale 1ns/1ps
module lnc_host_model (
    input  wire logic  clk_in,
    output logic       wr_strobe_out,
    output logic [7:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic       sync_pulse_out
);
    import lnc_pkg::*;
    initial begin
        wr_strobe_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 32'h0;
        sync_pulse_out = 1'b0;
    end
    function automatic logic [15:0] preload_for(input int unsigned period);
        return 16'(period / 4 + 1);
    endfunction
    // One-cycle write; gap idles the port afterwards to play a slow processor
    task automatic write_word(input logic [7:0] addr, input logic [31:0] data, input int gap);
        @(posedge clk_in);
        #1;
        wr_strobe_out = 1'b1;
        wr_addr_out = addr;
        wr_data_out = data;
        @(posedge clk_in);
        #1;
        wr_strobe_out = 1'b0;
        // Unqualified lines never keep a stale word that could pass for a write
        wr_addr_out = ~addr;
        wr_data_out = ~data;
        repeat (gap) @(posedge clk_in);
        #1;
    endtask
    task automatic pulse_sync(input int width);
        @(posedge clk_in);
        #1;
        sync_pulse_out = 1'b1;
        repeat (width) @(posedge clk_in);
        #1;
        sync_pulse_out = 1'b0;
    endtask
endmodule // lnc_host_model

// *** verif/tb_top.sv ***
// Self-checking bench for the control word block with its host model.
// Assumes inputs change 1 ns after the rising clock edge.
`timescale 1ns/1ps
module tb_top;
    import lnc_pkg::*;
    logic clk_in, rst_n, wr_strobe, sync_en, sync_pulse, enable_low;
    logic sync_pend, freq_pend, phase_pend, lvl_valid, lvl_busy;
    logic [7:0] wr_addr;
    logic [31:0] wr_data, act_freq, accum, snap;
    logic [9:0] act_phase, car_phase;
    logic [13:0] sample;
    logic [LNC_ACC_W-1:0] lvl_result;
    int fail_count = 0;
    int n_tests = 0;
    int n;
    lnc_host_model host (.clk_in(clk_in), .wr_strobe_out(wr_strobe), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .sync_pulse_out(sync_pulse));
    lnc_control_words #(.ACC_W(LNC_ACC_W)) uut (.CLK_IN(clk_in), .RST_N_IN(rst_n), .WR_STROBE_IN(wr_strobe),
        .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .NCO_SYNC_ENABLE_IN(sync_en),
        .FRONT_SYNC_PULSE_IN(sync_pulse), .SAMPLE_ENABLE_LOW_IN(enable_low), .SAMPLE_IN(sample),
        .ACTIVE_FREQUENCY_OUT(act_freq), .ACTIVE_PHASE_OFFSET_OUT(act_phase), .NCO_ACCUM_OUT(accum),
        .CARRIER_PHASE_OUT(car_phase), .SYNC_LOAD_PENDING_OUT(sync_pend), .FREQ_LOAD_PENDING_OUT(freq_pend),
        .PHASE_LOAD_PENDING_OUT(phase_pend), .LEVEL_RESULT_OUT(lvl_result),
        .LEVEL_RESULT_VALID_OUT(lvl_valid), .LEVEL_BUSY_OUT(lvl_busy));
    always #25 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    // Enable pin low long enough to clear the two input flops and apply loads
    task automatic run_nco(input int k);
        enable_low = 1'b0;
        cycles(k);
        enable_low = 1'b1;
        cycles(4);
    endtask
    task automatic wait_valid(output int w);
        w = 0;
        while (lvl_valid !== 1'b1 && w < 60) begin
            cycles(1);
            w++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_freq();
        chk(act_freq, 0);
        host.write_word(LNC_CW_CENTER_FREQ, 32'h1234_5678, 3);
        chk(act_freq, 0);
        host.write_word(LNC_CW_FREQ_STROBE, 32'hdead_beef, 2);
        chk(freq_pend, 1);
        chk(act_freq, 0);
        enable_low = 1'b0;
        cycles(6);
        chk(act_freq, 32'h1234_5678);
        snap = accum;
        cycles(1);
        chk(32'(accum - snap), 32'h1234_5678);
        enable_low = 1'b1;
        cycles(4);
        snap = accum;
        cycles(3);
        chk(accum, snap);
    endtask
    // Last update used the accumulator one increment back; the large offset makes the sum wrap
    task automatic t_phase();
        host.write_word(LNC_CW_PHASE_OFFSET, 32'hffff_fea5, 0);
        host.write_word(LNC_CW_PHASE_STROBE, 32'h0000_0001, 1);
        chk(phase_pend, 1);
        chk(act_phase, 0);
        run_nco(6);
        chk(act_phase, 10'h2a5);
        chk(phase_pend, 0);
        chk(car_phase, 10'(((accum - 32'h1234_5678) >> 22) + 32'h2a5));
    endtask
    task automatic t_sync();
        host.write_word(LNC_CW_CENTER_FREQ, 32'h0000_1000, 0);
        host.write_word(LNC_CW_PHASE_OFFSET, 32'h0000_0155, 0);
        host.pulse_sync(2);
        cycles(6);
        chk(sync_pend, 0);
        sync_en = 1'b1;
        host.pulse_sync(2);
        cycles(6);
        chk(sync_pend, 1);
        chk(act_freq, 32'h1234_5678);
        run_nco(6);
        chk(act_freq, 32'h0000_1000);
        chk(act_phase, 10'h155);
        chk(sync_pend, 0);
        sync_en = 1'b0;
    endtask
    // Negative threshold and negative sample prove sign extension and magnitude
    task automatic t_level_once();
        sample = 14'h3f9c;
        host.write_word(LNC_CW_LEVEL_CONFIG, {2'b10, host.preload_for(8), 14'h3ffb}, 0);
        host.write_word(LNC_CW_LEVEL_START, 32'h0, 0);
        wait_valid(n);
        chk(lvl_result, 64'd760);
        cycles(12);
        chk(lvl_busy, 0);
        chk(lvl_valid, 0);
    endtask
    // Sums repeat every period, so only the restart's timing shows that it happened
    task automatic t_level_run();
        sample = 14'd50;
        host.write_word(LNC_CW_LEVEL_CONFIG, {2'b01, host.preload_for(4), 14'h0010}, 0);
        host.write_word(LNC_CW_LEVEL_START, 32'hffff_ffff, 0);
        wait_valid(n);
        chk(lvl_result, 64'd264);
        cycles(1);
        wait_valid(n);
        chk(64'(n), 64'd3);
        chk(lvl_busy, 1);
        host.write_word(LNC_CW_LEVEL_START, 32'h0, 0);
        cycles(1);
        wait_valid(n);
        chk(64'(n), 64'd5);
        chk(lvl_result, 64'd264);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        rst_n = 1'b0;
        sync_en = 1'b0;
        enable_low = 1'b1;
        sample = 14'h0;
        repeat (8) @(posedge clk_in);
        #1;
        rst_n = 1'b1;
        cycles(3);
        t_freq();
        t_phase();
        t_sync();
        t_level_once();
        t_level_run();
        give_verdict();
    end
    // Whole run is about 130 cycles; this limit only catches a hang
    initial begin
        repeat (4000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
endmodule // tb_top
